// File: src/pcsia_pkg.sv
// package for the program-sequencing and indirect-addressing core
// assumes an 11-bit counter variant with four 512-word pages
`default_nettype none
package pcsia_pkg;
  localparam int PC_W        = 11;
  localparam int PAGE_W      = 2;
  localparam int PTR_W       = 7;
  localparam int FADDR_W     = 5;
  localparam int BANK_W      = 2;
  localparam int JUMP_W      = 9;
  localparam int LOW_W       = 8;
  localparam logic [PC_W-1:0]    PC_RESET   = 11'h7FF;
  localparam logic [PC_W-1:0]    PC_ONE     = 11'h001;
  localparam logic [PAGE_W-1:0]  PAGE_RESET = 2'h0;
  localparam logic [FADDR_W-1:0] ADDR_PORT  = 5'h00;
  localparam logic [LOW_W-1:0]   DATA_ZERO  = 8'h00;
  localparam logic [PTR_W-1:0]   PTR_RESET  = 7'h00;
  // counter load kinds from the decoder
  typedef enum logic [3:0] {
    PCSIA_OP_SEQ  = 4'h1,
    PCSIA_OP_JUMP = 4'h2,
    PCSIA_OP_CALL = 4'h4,
    PCSIA_OP_RET  = 4'h8
  } pcsia_op_e;
endpackage
`default_nettype wire

// File: src/pcsia_stack.sv
// two-level return stack
// assumes one push or pop per instruction cycle from the sequencer
`default_nettype none
module pcsia_stack (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_rst,
  input  wire logic                      i_push,
  input  wire logic                      i_pop,
  input  wire logic [pcsia_pkg::PC_W-1:0] i_push_addr,
  output logic      [pcsia_pkg::PC_W-1:0] o_top_of_stack_entry
);
  logic [pcsia_pkg::PC_W-1:0] lvl1_r, lvl1_nxt;
  logic [pcsia_pkg::PC_W-1:0] lvl2_r, lvl2_nxt;

  always_comb begin
    lvl1_nxt = lvl1_r;
    lvl2_nxt = lvl2_r;
    if (i_push) begin
      lvl2_nxt = lvl1_r;
      lvl1_nxt = i_push_addr;
    end else if (i_pop) begin
      lvl1_nxt = lvl2_r; // level 2 kept, so extra pops reuse it
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      lvl1_r <= pcsia_pkg::PC_RESET;
      lvl2_r <= pcsia_pkg::PC_RESET;
    end else begin
      lvl1_r <= lvl1_nxt;
      lvl2_r <= lvl2_nxt;
    end
  end

  assign o_top_of_stack_entry = lvl1_r;

  property p_push_shift;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_push |=> (lvl2_r == $past(lvl1_r)) && (lvl1_r == $past(i_push_addr));
  endproperty
  a_push_shift: assert property (p_push_shift) else $error("push did not shift");

  property p_pop_copy;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_pop && !i_push) |=> (lvl1_r == $past(lvl2_r)) && $stable(lvl2_r);
  endproperty
  a_pop_copy: assert property (p_pop_copy) else $error("pop did not copy level 2");
endmodule
`default_nettype wire

// File: src/pcsia_core.sv
// program counter, page preselect, return stack and indirect addressing
// assumes decoder presents one decoded instruction per clock (instruction cycle)
//
// Contract
// - counter increments each cycle unless the instruction loads it
// - jump loads counter bits 8:0 from the instruction address field
// - counter low byte is readable and writable as a file register
// - jumps, calls and low-byte writes take bits 10:9 from page preselect
// - call or low-byte write loads bits 7:0 and clears bit 8
// - move, add and bit-set to the low byte count as counter writes
// - incrementing across a page leaves page preselect unchanged
// - reset sets every counter bit to one
// - reset clears page preselect to page 0
// - two-entry return stack, each entry as wide as the counter
// - return loads counter from level 1, level 2 to 1, literal to accumulator
// - indirect data port has no storage, redirects through the pointer
// - indirect read with pointer address zero returns zero
// - indirect write to the port itself changes no register
// - page preselect 00 to 11 selects 512-word pages 0 to 3
// - pointer bits 4:0 select address, bits 6:5 select bank
`default_nettype none
module pcsia_core (
  input  wire logic                           i_ref_clk,
  input  wire logic                           i_rst,
  input  wire pcsia_pkg::pcsia_op_e           i_op,
  input  wire logic [pcsia_pkg::JUMP_W-1:0]   i_jump_addr,
  input  wire logic [pcsia_pkg::LOW_W-1:0]    i_result,
  input  wire logic                           i_low_byte_wr,
  input  wire logic [pcsia_pkg::LOW_W-1:0]    i_literal,
  input  wire logic                           i_page_wr,
  input  wire logic [pcsia_pkg::PAGE_W-1:0]   i_page_preselect,
  input  wire logic                           i_ptr_wr,
  input  wire logic [pcsia_pkg::PTR_W-1:0]    i_ptr_data,
  input  wire logic                           i_ind_rd,
  input  wire logic                           i_ind_wr,
  input  wire logic [pcsia_pkg::LOW_W-1:0]    i_ind_wdata,
  input  wire logic [pcsia_pkg::LOW_W-1:0]    i_file_rdata,
  output logic      [pcsia_pkg::PC_W-1:0]     o_pc,
  output logic      [pcsia_pkg::LOW_W-1:0]    o_counter_low_byte,
  output logic      [pcsia_pkg::PAGE_W-1:0]   o_page_preselect,
  output logic      [pcsia_pkg::PTR_W-1:0]    o_indirect_pointer,
  output logic      [pcsia_pkg::LOW_W-1:0]    o_acc_literal,
  output logic                                o_acc_load,
  output logic      [pcsia_pkg::FADDR_W-1:0]  o_file_addr,
  output logic      [pcsia_pkg::BANK_W-1:0]   o_file_bank,
  output logic                                o_file_wr,
  output logic      [pcsia_pkg::LOW_W-1:0]    o_file_wdata,
  output logic      [pcsia_pkg::LOW_W-1:0]    o_ind_rdata
);
  localparam int LB = pcsia_pkg::LOW_W;
  localparam int PB = pcsia_pkg::JUMP_W;

  logic [pcsia_pkg::PC_W-1:0]    pc_r, pc_nxt;
  logic [pcsia_pkg::PAGE_W-1:0]  page_r, page_nxt;
  logic [pcsia_pkg::PTR_W-1:0]   ptr_r, ptr_nxt;
  logic [pcsia_pkg::LOW_W-1:0]   lit_r, lit_nxt;
  logic                          accl_r, accl_nxt;
  logic [pcsia_pkg::FADDR_W-1:0] fa_r, fa_nxt;
  logic [pcsia_pkg::BANK_W-1:0]  fb_r, fb_nxt;
  logic                          fw_r, fw_nxt;
  logic [pcsia_pkg::LOW_W-1:0]   fd_r, fd_nxt;
  logic [pcsia_pkg::LOW_W-1:0]   ird_r, ird_nxt;
  logic [pcsia_pkg::PC_W-1:0]    pc_inc;
  logic [pcsia_pkg::PC_W-1:0]    top_of_stack_entry;
  logic                          do_push;
  logic                          do_pop;
  logic                          ptr_self;

  assign pc_inc   = pc_r + pcsia_pkg::PC_ONE;
  assign do_push  = (i_op == pcsia_pkg::PCSIA_OP_CALL);
  assign do_pop   = (i_op == pcsia_pkg::PCSIA_OP_RET);
  assign ptr_self = (ptr_r[pcsia_pkg::FADDR_W-1:0] == pcsia_pkg::ADDR_PORT);

  // stack entries match counter width
  pcsia_stack u_stack (
    .i_ref_clk            (i_ref_clk),
    .i_rst                (i_rst),
    .i_push               (do_push),
    .i_pop                (do_pop),
    .i_push_addr          (pc_inc),
    .o_top_of_stack_entry (top_of_stack_entry)
  );

  // program counter and page preselect
  always_comb begin
    pc_nxt   = pc_inc; // page preselect untouched by carry
    page_nxt = page_r;
    if (i_page_wr) begin
      page_nxt = i_page_preselect;
    end
    if (do_pop) begin
      pc_nxt = top_of_stack_entry;
    end else if (do_push || i_low_byte_wr) begin
      // bit 8 forced low; targets limited to first half-page
      pc_nxt = {page_r, 1'b0, i_result};
    end else if (i_op == pcsia_pkg::PCSIA_OP_JUMP) begin
      pc_nxt = {page_r, i_jump_addr};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pc_r   <= pcsia_pkg::PC_RESET;
      page_r <= pcsia_pkg::PAGE_RESET;
    end else begin
      pc_r   <= pc_nxt;
      page_r <= page_nxt;
    end
  end

  // accumulator literal on return
  always_comb begin
    lit_nxt  = lit_r;
    accl_nxt = do_pop;
    if (do_pop) begin
      lit_nxt = i_literal;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      lit_r  <= pcsia_pkg::DATA_ZERO;
      accl_r <= 1'b0;
    end else begin
      lit_r  <= lit_nxt;
      accl_r <= accl_nxt;
    end
  end

  // indirect access: no storage in the port, pointer selects target
  always_comb begin
    ptr_nxt = ptr_r;
    fw_nxt  = i_ind_wr && !ptr_self; // self-target write is a no-op
    fd_nxt  = i_ind_wdata;
    ird_nxt = ird_r;
    if (i_ptr_wr) begin
      ptr_nxt = i_ptr_data;
    end
    // address follows the new pointer, so a read right after a pointer write never lags
    fa_nxt  = ptr_nxt[pcsia_pkg::FADDR_W-1:0];
    fb_nxt  = ptr_nxt[pcsia_pkg::PTR_W-1:pcsia_pkg::FADDR_W];
    if (i_ind_rd) begin
      ird_nxt = ptr_self ? pcsia_pkg::DATA_ZERO : i_file_rdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ptr_r <= pcsia_pkg::PTR_RESET;
      fa_r  <= pcsia_pkg::ADDR_PORT;
      fb_r  <= '0;
      fw_r  <= 1'b0;
      fd_r  <= pcsia_pkg::DATA_ZERO;
      ird_r <= pcsia_pkg::DATA_ZERO;
    end else begin
      ptr_r <= ptr_nxt;
      fa_r  <= fa_nxt;
      fb_r  <= fb_nxt;
      fw_r  <= fw_nxt;
      fd_r  <= fd_nxt;
      ird_r <= ird_nxt;
    end
  end

  assign o_pc               = pc_r;
  assign o_counter_low_byte = pc_r[LB-1:0];
  assign o_page_preselect   = page_r;
  assign o_indirect_pointer = ptr_r;
  assign o_acc_literal      = lit_r;
  assign o_acc_load         = accl_r;
  assign o_file_addr        = fa_r;
  assign o_file_bank        = fb_r;
  assign o_file_wr          = fw_r;
  assign o_file_wdata       = fd_r;
  assign o_ind_rdata        = ird_r;

  sequence s_plain;
    i_op == pcsia_pkg::PCSIA_OP_SEQ && !i_low_byte_wr;
  endsequence

  property p_incr;
    @(posedge i_ref_clk) disable iff (i_rst)
      s_plain |=> pc_r == $past(pc_r) + pcsia_pkg::PC_ONE;
  endproperty
  a_incr: assert property (p_incr) else $error("counter did not increment");

  property p_jump;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_op == pcsia_pkg::PCSIA_OP_JUMP && !i_low_byte_wr) |=>
        pc_r == {$past(page_r), $past(i_jump_addr)};
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong");

  property p_low_write;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_low_byte_wr && !do_pop) |=>
        !pc_r[PB-1] && pc_r[LB-1:0] == $past(i_result)
        && pc_r[pcsia_pkg::PC_W-1:PB] == $past(page_r);
  endproperty
  a_low_write: assert property (p_low_write) else $error("low byte load wrong");

  property p_page_hold;
    @(posedge i_ref_clk) disable iff (i_rst)
      !i_page_wr |=> $stable(page_r);
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("page changed by itself");

  property p_reset_vec;
    @(posedge i_ref_clk) $past(i_rst) |-> pc_r == pcsia_pkg::PC_RESET && page_r == '0;
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset values wrong");

  property p_ret;
    @(posedge i_ref_clk) disable iff (i_rst)
      do_pop |=> pc_r == $past(top_of_stack_entry) && o_acc_load && o_acc_literal == $past(i_literal);
  endproperty
  a_ret: assert property (p_ret) else $error("return did not load");

  property p_self_read;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_ind_rd && ptr_self) |=> o_ind_rdata == pcsia_pkg::DATA_ZERO;
  endproperty
  a_self_read: assert property (p_self_read) else $error("self read not zero");

  property p_self_write;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_ind_wr && ptr_self) |=> !o_file_wr;
  endproperty
  a_self_write: assert property (p_self_write) else $error("self write not blocked");
endmodule
`default_nettype wire

// File: sim/pcsia_file_model.sv
// file register array behind the indirect data port
// assumes address and bank are the core's registered pointer split
`default_nettype none
module pcsia_file_model (
  input  wire logic       i_ref_clk,
  input  wire logic [4:0] i_addr,
  input  wire logic [1:0] i_bank,
  input  wire logic       i_wr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [128];
  // address zero is filled too, so the port must mask it
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 8'(i) ^ 8'hA5;
  end
  always @(posedge i_ref_clk) begin
    if (i_wr) mem[{i_bank, i_addr}] <= i_wdata;
  end
  assign o_rdata = mem[{i_bank, i_addr}];
endmodule
`default_nettype wire

// File: sim/pcsia_core_tb_top.sv
// self-checking bench for the sequencing and indirect core
// assumes the file model answers reads in the same cycle
`default_nettype none
module pcsia_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  pcsia_pkg::pcsia_op_e op = pcsia_pkg::PCSIA_OP_SEQ;
  logic [8:0]  ja = 9'h000;
  logic [7:0]  res = 8'h00, lit = 8'h00, wd = 8'h00, frd, lb, al, fwd, ird;
  logic [1:0]  pg = 2'h0, pgo, fb;
  logic [6:0]  pd = 7'h00, ptr;
  logic [4:0]  fa;
  logic [10:0] pc;
  logic        lbw = 1'b0, pgw = 1'b0, pw = 1'b0, ir = 1'b0, iw = 1'b0, aload, fw;
  int          fails = 0, check_count = 0;
  always #20 clk = ~clk;
  pcsia_core u_pcsia_core (.i_ref_clk(clk), .i_rst(rst), .i_op(op), .i_jump_addr(ja),
    .i_result(res), .i_low_byte_wr(lbw), .i_literal(lit), .i_page_wr(pgw),
    .i_page_preselect(pg), .i_ptr_wr(pw), .i_ptr_data(pd), .i_ind_rd(ir), .i_ind_wr(iw),
    .i_ind_wdata(wd), .i_file_rdata(frd), .o_pc(pc), .o_counter_low_byte(lb),
    .o_page_preselect(pgo), .o_indirect_pointer(ptr), .o_acc_literal(al),
    .o_acc_load(aload), .o_file_addr(fa), .o_file_bank(fb), .o_file_wr(fw),
    .o_file_wdata(fwd), .o_ind_rdata(ird));
  pcsia_file_model u_pcsia_file_model (.i_ref_clk(clk), .i_addr(fa), .i_bank(fb),
    .i_wr(fw), .i_wdata(fwd), .o_rdata(frd));
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one instruction cycle; flags are low-byte, page, pointer, read, write
  task automatic step(input pcsia_pkg::pcsia_op_e o, input logic [4:0] f);
    op = o;
    {lbw, pgw, pw, ir, iw} = f;
    @(negedge clk);
  endtask
  task automatic t_reset();
    repeat (4) @(negedge clk);
    chk(pc, 11'h7FF);
    chk(11'(pgo), 11'h000);
    chk(11'(ptr), 11'h000);
    rst = 1'b0;
    $display("test reset done");
  endtask
  task automatic t_branch();
    ja = 9'h1FF;
    step(pcsia_pkg::PCSIA_OP_JUMP, 5'h00);
    chk(pc, 11'h1FF);
    step(pcsia_pkg::PCSIA_OP_SEQ, 5'h00);
    chk(pc, 11'h200);
    chk(11'(pgo), 11'h000);
    ja = 9'h0AA;
    step(pcsia_pkg::PCSIA_OP_JUMP, 5'h00);
    chk(pc, 11'h0AA);
    $display("test branch done");
  endtask
  task automatic t_stack();
    pg = 2'h1;
    step(pcsia_pkg::PCSIA_OP_SEQ, 5'h08);
    chk(pc, 11'h0AB);
    // targets stay in the low half of the page
    res = 8'h10;
    step(pcsia_pkg::PCSIA_OP_CALL, 5'h00);
    chk(pc, 11'h210);
    res = 8'h20;
    step(pcsia_pkg::PCSIA_OP_CALL, 5'h00);
    chk(pc, 11'h220);
    res = 8'h30;
    step(pcsia_pkg::PCSIA_OP_CALL, 5'h00);
    chk(pc, 11'h230);
    lit = 8'h5A;
    step(pcsia_pkg::PCSIA_OP_RET, 5'h00);
    chk(pc, 11'h221);
    chk(11'(al), 11'h05A);
    chk(11'(aload), 11'h001);
    step(pcsia_pkg::PCSIA_OP_RET, 5'h00);
    chk(pc, 11'h211);
    step(pcsia_pkg::PCSIA_OP_RET, 5'h00);
    chk(pc, 11'h211);
    $display("test stack done");
  endtask
  task automatic t_low();
    pg = 2'h3;
    step(pcsia_pkg::PCSIA_OP_SEQ, 5'h08);
    ja = 9'h1F0;
    step(pcsia_pkg::PCSIA_OP_JUMP, 5'h00);
    chk(pc, 11'h7F0);
    res = 8'h12;
    step(pcsia_pkg::PCSIA_OP_SEQ, 5'h10);
    chk(pc, 11'h612);
    chk(11'(lb), 11'h012);
    $display("test low byte done");
  endtask
  task automatic t_ind();
    pd = 7'h65;
    step(pcsia_pkg::PCSIA_OP_SEQ, 5'h04);
    chk(11'({fb, fa}), 11'h065);
    chk(11'(ptr), 11'h065);
    step(pcsia_pkg::PCSIA_OP_SEQ, 5'h02);
    chk(11'(ird), 11'(8'h65 ^ 8'hA5));
    wd = 8'hC3;
    step(pcsia_pkg::PCSIA_OP_SEQ, 5'h01);
    chk(11'({fw, fwd}), 11'h1C3);
    step(pcsia_pkg::PCSIA_OP_SEQ, 5'h00);
    step(pcsia_pkg::PCSIA_OP_SEQ, 5'h02);
    chk(11'(ird), 11'h0C3);
    pd = 7'h40;
    step(pcsia_pkg::PCSIA_OP_SEQ, 5'h04);
    step(pcsia_pkg::PCSIA_OP_SEQ, 5'h02);
    chk(11'(ird), 11'h000);
    wd = 8'h77;
    step(pcsia_pkg::PCSIA_OP_SEQ, 5'h01);
    chk(11'(fw), 11'h000);
    $display("test indirect done");
  endtask
  // reset again from a busy state: page 3, pointer 40h, stack loaded
  task automatic t_rerst();
    rst = 1'b1;
    step(pcsia_pkg::PCSIA_OP_SEQ, 5'h00);
    chk(pc, 11'h7FF);
    chk(11'(pgo), 11'h000);
    chk(11'(ptr), 11'h000);
    chk(11'(aload), 11'h000);
    rst = 1'b0;
    ja = 9'h055;
    step(pcsia_pkg::PCSIA_OP_JUMP, 5'h00);
    chk(pc, 11'h055);
    $display("test mid-run reset done");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // a hang counts as a mismatch
  initial begin
    repeat (2000) @(posedge clk);
    fails++;
    $display("timeout at %0t", $time);
    tally_and_finish();
  end
  initial begin
    t_reset();
    t_branch();
    t_stack();
    t_low();
    t_ind();
    t_rerst();
    tally_and_finish();
  end
endmodule
`default_nettype wire
